// *** rtc_pkg.sv ***
// Contract
// RULE_01: Host ends every bus transaction, start to stop, within 0.95 seconds.
// RULE_02: Bus interface returns to idle after 0.95 seconds without a stop.
// RULE_03: Seconds, minutes, hours, weekday, date, month, two-digit year; host sets and reads.
// RULE_04: Years divisible by four are leap years; February then has 29 days.
// RULE_05: Periodic timer event, period from 244.14 us up to 4095 minutes.
// RULE_06: Each timer event sets the timer event flag to 1.
// RULE_07: Interrupt pulls low for a timer event only while timer interrupt enable is 1.
// RULE_08: Interrupt output releases by itself within 7.8 ms; each event restarts the hold, so a 4096 Hz count under 32 keeps it low.
// RULE_09: Host writes can only clear event flags; a written 1 changes nothing.
// RULE_10: Interrupt output is open drain, active low, never driven high.
// RULE_11: Time advances once per second from 32.768 kHz, carrying into larger fields.
package rtc_pkg;

    // Time base
    localparam int XTAL_HZ = 32768;
    localparam int PRE_W = 15;
    localparam logic [PRE_W-1:0] PRE_SEC_MASK = 15'h7fff;
    localparam logic [PRE_W-1:0] PRE_4096_MASK = 15'h0007;
    localparam logic [PRE_W-1:0] PRE_64_MASK = 15'h01ff;

    // Interrupt release time, counted in crystal ticks
    localparam int IRQ_HOLD_US = 7800;
    localparam int IRQ_HOLD_TICKS = IRQ_HOLD_US * XTAL_HZ / 1000000;
    localparam int IRQ_W = 8;

    // Bus timeout, counted in system clocks
    localparam int CLK_HZ = 25000000;
    localparam int BUS_TIMEOUT_MS = 950;
    localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (CLK_HZ / 1000);

    // Bus device address, value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2a;

    // Register pointer map
    localparam logic [3:0] ADDR_SEC = 4'h0;
    localparam logic [3:0] ADDR_MIN = 4'h1;
    localparam logic [3:0] ADDR_HOUR = 4'h2;
    localparam logic [3:0] ADDR_WDAY = 4'h3;
    localparam logic [3:0] ADDR_DATE = 4'h4;
    localparam logic [3:0] ADDR_MONTH = 4'h5;
    localparam logic [3:0] ADDR_YEAR = 4'h6;
    localparam logic [3:0] ADDR_TMR_LO = 4'h7;
    localparam logic [3:0] ADDR_TMR_HI = 4'h8;
    localparam logic [3:0] ADDR_EXT = 4'h9;
    localparam logic [3:0] ADDR_FLAG = 4'ha;
    localparam logic [3:0] ADDR_CTRL = 4'hb;

    // Field positions
    localparam int EXT_SRC_LSB = 0;
    localparam int EXT_EN_BIT = 2;
    localparam int FLAG_TF_BIT = 4;
    localparam int CTRL_TIE_BIT = 4;

    // Timer source select codes
    localparam logic [1:0] SRC_4096HZ = 2'h0;
    localparam logic [1:0] SRC_64HZ = 2'h1;
    localparam logic [1:0] SRC_SEC = 2'h2;
    localparam logic [1:0] SRC_MIN = 2'h3;

    // Calendar limits and reset values
    localparam logic [5:0] SEC_MAX = 6'h3b;
    localparam logic [5:0] MIN_MAX = 6'h3b;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [2:0] WDAY_MAX = 3'h6;
    localparam logic [3:0] MONTH_MAX = 4'hc;
    localparam logic [6:0] YEAR_MAX = 7'h63;
    localparam logic [4:0] DATE_RST = 5'h01;
    localparam logic [3:0] MONTH_RST = 4'h1;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } rtc_wr_s;

endpackage : rtc_pkg

// *** rtc_i2c_slave.sv ***
`timescale 1ns/100ps
module rtc_i2c_slave (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic timeout_i,
    input wire logic [7:0] rd_data_i,
    output logic [3:0] ptr_o,
    output logic wr_en_o,
    output rtc_pkg::rtc_wr_s wr_o,
    output logic busy_o,
    output logic sda_oe_o
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_WDATA, S_WACK, S_RDATA, S_RACK} rtc_st_e;

    rtc_st_e st_ff, nxt_st;
    logic scl_q_ff, sda_q_ff;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh;
    logic [7:0] tx_ff, nxt_tx;
    logic [3:0] ptr_ff, nxt_ptr;
    logic first_ff, nxt_first;
    logic rw_ff, nxt_rw;
    logic oe_ff, nxt_oe;
    logic busy_ff, nxt_busy;
    logic wr_en_ff, nxt_wr_en;
    rtc_pkg::rtc_wr_s wr_ff, nxt_wr;
    logic scl_rise, scl_fall, start_c, stop_c;

    assign scl_rise = scl_i & ~scl_q_ff;
    assign scl_fall = ~scl_i & scl_q_ff;
    assign start_c = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
    assign stop_c = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_tx = tx_ff;
        nxt_ptr = ptr_ff;
        nxt_first = first_ff;
        nxt_rw = rw_ff;
        nxt_oe = oe_ff;
        nxt_busy = busy_ff;
        nxt_wr_en = 1'b0;
        nxt_wr = wr_ff;
        if (timeout_i) begin
            nxt_st = S_IDLE; // RULE_02
            nxt_oe = 1'b0;
            nxt_busy = 1'b0;
        end else if (start_c) begin
            nxt_st = S_ADDR;
            nxt_cnt = 4'h0;
            nxt_oe = 1'b0;
            nxt_busy = 1'b1;
        end else if (stop_c) begin
            nxt_st = S_IDLE;
            nxt_oe = 1'b0;
            nxt_busy = 1'b0;
        end else if (scl_rise) begin
            case (st_ff)
                S_ADDR, S_WDATA: begin
                    nxt_sh = {sh_ff[6:0], sda_i};
                    nxt_cnt = cnt_ff + 4'h1;
                end
                S_RDATA: nxt_cnt = cnt_ff + 4'h1;
                S_RACK: begin
                    if (sda_i) begin
                        nxt_st = S_IDLE;
                    end
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            case (st_ff)
                S_ADDR: begin
                    if (cnt_ff == 4'h8) begin
                        if (sh_ff[7:1] == rtc_pkg::DEV_ADDR) begin
                            nxt_st = S_AACK;
                            nxt_oe = 1'b1;
                            nxt_rw = sh_ff[0];
                        end else begin
                            nxt_st = S_IDLE;
                        end
                    end
                end
                S_AACK, S_RACK: begin
                    nxt_cnt = 4'h0;
                    if (st_ff == S_RACK || rw_ff) begin
                        nxt_st = S_RDATA;
                        nxt_tx = rd_data_i;
                        nxt_oe = ~rd_data_i[7];
                        nxt_ptr = ptr_ff + 4'h1;
                    end else begin
                        nxt_st = S_WDATA;
                        nxt_oe = 1'b0;
                        nxt_first = 1'b1;
                    end
                end
                S_WDATA: begin
                    if (cnt_ff == 4'h8) begin
                        nxt_st = S_WACK;
                        nxt_oe = 1'b1;
                        nxt_first = 1'b0;
                        if (first_ff) begin
                            nxt_ptr = sh_ff[3:0];
                        end else begin
                            nxt_wr_en = 1'b1; // RULE_03
                            nxt_wr.addr = ptr_ff;
                            nxt_wr.data = sh_ff;
                            nxt_ptr = ptr_ff + 4'h1;
                        end
                    end
                end
                S_WACK: begin
                    nxt_st = S_WDATA;
                    nxt_oe = 1'b0;
                    nxt_cnt = 4'h0;
                end
                S_RDATA: begin
                    if (cnt_ff == 4'h8) begin
                        nxt_st = S_RACK;
                        nxt_oe = 1'b0;
                    end else begin
                        nxt_tx = {tx_ff[6:0], 1'b0};
                        nxt_oe = ~tx_ff[6];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_ff <= S_IDLE;
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            tx_ff <= 8'h00;
            ptr_ff <= 4'h0;
            first_ff <= 1'b0;
            rw_ff <= 1'b0;
            oe_ff <= 1'b0;
            busy_ff <= 1'b0;
            wr_en_ff <= 1'b0;
            wr_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            scl_q_ff <= scl_i;
            sda_q_ff <= sda_i;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            tx_ff <= nxt_tx;
            ptr_ff <= nxt_ptr;
            first_ff <= nxt_first;
            rw_ff <= nxt_rw;
            oe_ff <= nxt_oe;
            busy_ff <= nxt_busy;
            wr_en_ff <= nxt_wr_en;
            wr_ff <= nxt_wr;
        end
    end

    assign ptr_o = ptr_ff;
    assign wr_en_o = wr_en_ff;
    assign wr_o = wr_ff;
    assign busy_o = busy_ff;
    assign sda_oe_o = oe_ff;
endmodule : rtc_i2c_slave

// *** rtc_core.sv ***
`timescale 1ns/100ps
module rtc_core #(
    parameter int unsigned BUS_TIMEOUT_CYC = rtc_pkg::BUS_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic xtal_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic int_n_o,
    output logic int_oe_o
);
    localparam int TO_W = $clog2(BUS_TIMEOUT_CYC + 1);

    function automatic logic [4:0] days_in_month(input logic [3:0] mon, input logic [6:0] yr);
        case (mon)
            4'h2: days_in_month = (yr[1:0] == 2'h0) ? 5'h1d : 5'h1c; // RULE_04
            4'h4, 4'h6, 4'h9, 4'hb: days_in_month = 5'h1e;
            default: days_in_month = 5'h1f;
        endcase
    endfunction : days_in_month

    // Pin synchronisers: xtal, scl, sda
    logic [2:0] sync1_ff, sync2_ff;
    logic xtal_s, scl_s, sda_s, xtal_q_ff, xtal_tick;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_ff <= 3'h6;
            sync2_ff <= 3'h6;
            xtal_q_ff <= 1'b0;
        end else begin
            sync1_ff <= {sda_i, scl_i, xtal_i};
            sync2_ff <= sync1_ff;
            xtal_q_ff <= sync2_ff[0];
        end
    end
    assign xtal_s = sync2_ff[0];
    assign scl_s = sync2_ff[1];
    assign sda_s = sync2_ff[2];
    assign xtal_tick = xtal_s & ~xtal_q_ff;

    // Bus slave
    logic [3:0] ptr;
    logic wr_en, busy, timeout;
    rtc_pkg::rtc_wr_s wr;
    logic [7:0] rd_data;

    rtc_i2c_slave u_slave (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .scl_i(scl_s),
        .sda_i(sda_s),
        .timeout_i(timeout),
        .rd_data_i(rd_data),
        .ptr_o(ptr),
        .wr_en_o(wr_en),
        .wr_o(wr),
        .busy_o(busy),
        .sda_oe_o(sda_oe_o)
    );
    assign sda_o = 1'b0;

    // Bus watchdog
    logic [TO_W-1:0] to_cnt_ff, nxt_to_cnt;
    logic to_ff, nxt_to;

    always_comb begin
        nxt_to = 1'b0;
        nxt_to_cnt = '0;
        if (busy && !to_ff) begin
            if (to_cnt_ff == TO_W'(BUS_TIMEOUT_CYC - 1)) begin
                nxt_to = 1'b1; // RULE_02
            end else begin
                nxt_to_cnt = to_cnt_ff + 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            to_cnt_ff <= '0;
            to_ff <= 1'b0;
        end else begin
            to_cnt_ff <= nxt_to_cnt;
            to_ff <= nxt_to;
        end
    end
    assign timeout = to_ff;

    // Calendar
    logic [rtc_pkg::PRE_W-1:0] pre_ff, nxt_pre;
    logic [5:0] sec_ff, nxt_sec, min_ff, nxt_min;
    logic [4:0] hour_ff, nxt_hour, date_ff, nxt_date;
    logic [2:0] wday_ff, nxt_wday;
    logic [3:0] month_ff, nxt_month;
    logic [6:0] year_ff, nxt_year;
    logic sec_tick;

    assign sec_tick = xtal_tick && pre_ff == rtc_pkg::PRE_SEC_MASK; // RULE_11

    always_comb begin
        nxt_pre = xtal_tick ? pre_ff + 1'b1 : pre_ff;
        nxt_sec = sec_ff;
        nxt_min = min_ff;
        nxt_hour = hour_ff;
        nxt_wday = wday_ff;
        nxt_date = date_ff;
        nxt_month = month_ff;
        nxt_year = year_ff;
        if (sec_tick) begin
            nxt_sec = sec_ff + 6'h1;
            if (sec_ff == rtc_pkg::SEC_MAX) begin // RULE_11
                nxt_sec = 6'h0;
                nxt_min = min_ff + 6'h1;
                if (min_ff == rtc_pkg::MIN_MAX) begin
                    nxt_min = 6'h0;
                    nxt_hour = hour_ff + 5'h1;
                    if (hour_ff == rtc_pkg::HOUR_MAX) begin
                        nxt_hour = 5'h0;
                        nxt_wday = (wday_ff == rtc_pkg::WDAY_MAX) ? 3'h0 : wday_ff + 3'h1;
                        nxt_date = date_ff + 5'h1;
                        if (date_ff == days_in_month(month_ff, year_ff)) begin // RULE_04
                            nxt_date = rtc_pkg::DATE_RST;
                            nxt_month = month_ff + 4'h1;
                            if (month_ff == rtc_pkg::MONTH_MAX) begin
                                nxt_month = rtc_pkg::MONTH_RST;
                                nxt_year = (year_ff == rtc_pkg::YEAR_MAX) ? 7'h0 : year_ff + 7'h1;
                            end
                        end
                    end
                end
            end
        end
        if (wr_en) begin
            case (wr.addr) // RULE_03
                rtc_pkg::ADDR_SEC: begin
                    nxt_sec = wr.data[5:0];
                    nxt_pre = '0;
                end
                rtc_pkg::ADDR_MIN: nxt_min = wr.data[5:0];
                rtc_pkg::ADDR_HOUR: nxt_hour = wr.data[4:0];
                rtc_pkg::ADDR_WDAY: nxt_wday = wr.data[2:0];
                rtc_pkg::ADDR_DATE: nxt_date = wr.data[4:0];
                rtc_pkg::ADDR_MONTH: nxt_month = wr.data[3:0];
                rtc_pkg::ADDR_YEAR: nxt_year = wr.data[6:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_ff <= '0;
            sec_ff <= 6'h0;
            min_ff <= 6'h0;
            hour_ff <= 5'h0;
            wday_ff <= 3'h0;
            date_ff <= rtc_pkg::DATE_RST;
            month_ff <= rtc_pkg::MONTH_RST;
            year_ff <= 7'h0;
        end else begin
            pre_ff <= nxt_pre;
            sec_ff <= nxt_sec;
            min_ff <= nxt_min;
            hour_ff <= nxt_hour;
            wday_ff <= nxt_wday;
            date_ff <= nxt_date;
            month_ff <= nxt_month;
            year_ff <= nxt_year;
        end
    end

    // Fixed-cycle timer and interrupt
    logic [11:0] tmr_load_ff, nxt_tmr_load, tmr_cnt_ff, nxt_tmr_cnt;
    logic [1:0] tmr_src_ff, nxt_tmr_src;
    logic tmr_en_ff, nxt_tmr_en, timer_event_flag_ff, nxt_timer_event_flag;
    logic timer_irq_enable_ff, nxt_timer_irq_enable, irq_on_ff, nxt_irq_on;
    logic [rtc_pkg::IRQ_W-1:0] irq_cnt_ff, nxt_irq_cnt;
    logic src_tick, tmr_event;

    always_comb begin
        case (tmr_src_ff) // RULE_05
            rtc_pkg::SRC_4096HZ: src_tick = xtal_tick && (pre_ff & rtc_pkg::PRE_4096_MASK) ==
                rtc_pkg::PRE_4096_MASK;
            rtc_pkg::SRC_64HZ: src_tick = xtal_tick && (pre_ff & rtc_pkg::PRE_64_MASK) ==
                rtc_pkg::PRE_64_MASK;
            rtc_pkg::SRC_SEC: src_tick = sec_tick;
            default: src_tick = sec_tick && sec_ff == rtc_pkg::SEC_MAX;
        endcase
        tmr_event = tmr_en_ff && src_tick && tmr_load_ff != 12'h0 && tmr_cnt_ff <= 12'h1;
        nxt_tmr_load = tmr_load_ff;
        nxt_tmr_src = tmr_src_ff;
        nxt_tmr_en = tmr_en_ff;
        nxt_timer_irq_enable = timer_irq_enable_ff;
        nxt_timer_event_flag = timer_event_flag_ff;
        nxt_tmr_cnt = tmr_cnt_ff;
        if (!tmr_en_ff || tmr_event) begin
            nxt_tmr_cnt = tmr_load_ff; // RULE_05
        end else if (src_tick) begin
            nxt_tmr_cnt = tmr_cnt_ff - 12'h1;
        end
        if (wr_en) begin
            case (wr.addr)
                rtc_pkg::ADDR_TMR_LO: nxt_tmr_load = {tmr_load_ff[11:8], wr.data};
                rtc_pkg::ADDR_TMR_HI: nxt_tmr_load = {wr.data[3:0], tmr_load_ff[7:0]};
                rtc_pkg::ADDR_EXT: begin
                    nxt_tmr_src = wr.data[rtc_pkg::EXT_SRC_LSB +: 2];
                    nxt_tmr_en = wr.data[rtc_pkg::EXT_EN_BIT];
                end
                rtc_pkg::ADDR_FLAG: begin
                    if (!wr.data[rtc_pkg::FLAG_TF_BIT]) begin
                        nxt_timer_event_flag = 1'b0; // RULE_09
                    end
                end
                rtc_pkg::ADDR_CTRL: nxt_timer_irq_enable = wr.data[rtc_pkg::CTRL_TIE_BIT];
                default: ;
            endcase
        end
        if (tmr_event) begin
            nxt_timer_event_flag = 1'b1; // RULE_06
        end
        nxt_irq_cnt = irq_cnt_ff;
        if (tmr_event && timer_irq_enable_ff) begin
            nxt_irq_cnt = rtc_pkg::IRQ_W'(rtc_pkg::IRQ_HOLD_TICKS); // RULE_07
        end else if (!timer_irq_enable_ff) begin
            nxt_irq_cnt = '0; // RULE_07
        end else if (xtal_tick && irq_cnt_ff != '0) begin
            nxt_irq_cnt = irq_cnt_ff - 1'b1; // RULE_08
        end
        nxt_irq_on = nxt_irq_cnt != '0;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tmr_load_ff <= 12'h0;
            tmr_cnt_ff <= 12'h0;
            tmr_src_ff <= rtc_pkg::SRC_4096HZ;
            tmr_en_ff <= 1'b0;
            timer_event_flag_ff <= 1'b0;
            timer_irq_enable_ff <= 1'b0;
            irq_cnt_ff <= '0;
            irq_on_ff <= 1'b0;
        end else begin
            tmr_load_ff <= nxt_tmr_load;
            tmr_cnt_ff <= nxt_tmr_cnt;
            tmr_src_ff <= nxt_tmr_src;
            tmr_en_ff <= nxt_tmr_en;
            timer_event_flag_ff <= nxt_timer_event_flag;
            timer_irq_enable_ff <= nxt_timer_irq_enable;
            irq_cnt_ff <= nxt_irq_cnt;
            irq_on_ff <= nxt_irq_on;
        end
    end
    assign int_n_o = 1'b0; // RULE_10
    assign int_oe_o = irq_on_ff; // RULE_10

    // Read back
    always_comb begin
        case (ptr) // RULE_03
            rtc_pkg::ADDR_SEC: rd_data = {2'h0, sec_ff};
            rtc_pkg::ADDR_MIN: rd_data = {2'h0, min_ff};
            rtc_pkg::ADDR_HOUR: rd_data = {3'h0, hour_ff};
            rtc_pkg::ADDR_WDAY: rd_data = {5'h0, wday_ff};
            rtc_pkg::ADDR_DATE: rd_data = {3'h0, date_ff};
            rtc_pkg::ADDR_MONTH: rd_data = {4'h0, month_ff};
            rtc_pkg::ADDR_YEAR: rd_data = {1'h0, year_ff};
            rtc_pkg::ADDR_TMR_LO: rd_data = tmr_load_ff[7:0];
            rtc_pkg::ADDR_TMR_HI: rd_data = {4'h0, tmr_load_ff[11:8]};
            rtc_pkg::ADDR_EXT: rd_data = {5'h0, tmr_en_ff, tmr_src_ff};
            rtc_pkg::ADDR_FLAG: rd_data = {3'h0, timer_event_flag_ff, 4'h0};
            rtc_pkg::ADDR_CTRL: rd_data = {3'h0, timer_irq_enable_ff, 4'h0};
            default: rd_data = 8'h00;
        endcase
    end
endmodule : rtc_core

// *** rtc_chk.sv ***
`timescale 1ns/100ps
module rtc_chk #(
    parameter int unsigned BUS_TIMEOUT_CYC = 3000
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic xtal_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic int_n_o,
    input wire logic int_oe_o
);
    logic [2:0] scl_ff, sda_ff, xt_ff, nxt_scl, nxt_sda, nxt_xt;
    logic open_ff, nxt_open;
    logic [31:0] bus_ff, nxt_bus;
    logic [8:0] hold_ff, nxt_hold;
    // Bus open time in system clocks and interrupt width in crystal ticks
    always_comb begin
        nxt_scl = {scl_ff[1:0], scl_i};
        nxt_sda = {sda_ff[1:0], sda_i};
        nxt_xt = {xt_ff[1:0], xtal_i};
        nxt_open = open_ff;
        if (&scl_ff[2:1] && sda_ff[2] != sda_ff[1]) nxt_open = sda_ff[2];
        nxt_bus = open_ff ? bus_ff + 32'h1 : 32'h0;
        nxt_hold = int_oe_o ? hold_ff + {8'h0, xt_ff[1] & ~xt_ff[2]} : 9'h0;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_ff <= 3'h7;
            sda_ff <= 3'h7;
            xt_ff <= 3'h0;
            open_ff <= 1'b0;
            bus_ff <= 32'h0;
            hold_ff <= 9'h0;
        end else begin
            scl_ff <= nxt_scl;
            sda_ff <= nxt_sda;
            xt_ff <= nxt_xt;
            open_ff <= nxt_open;
            bus_ff <= nxt_bus;
            hold_ff <= nxt_hold;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_int_od_low: assert property (int_n_o == 1'b0 && sda_o == 1'b0)
        else $error("open drain output driven high");
    a_int_release: assert property (hold_ff <= 9'h100)
        else $error("interrupt held too long");
    a_int_width: assert property ($fell(int_oe_o) |-> $past(hold_ff) >= 9'h0fe)
        else $error("interrupt released early");
    a_int_hold: assert property ($rose(int_oe_o) |-> int_oe_o [*8])
        else $error("interrupt glitch");
    a_bus_timeout: assert property (bus_ff >= BUS_TIMEOUT_CYC + 8 |-> !sda_oe_o)
        else $error("data line held after bus timeout");
    a_idle_quiet: assert property (!open_ff && !$past(open_ff) |-> !sda_oe_o)
        else $error("data line driven while bus idle");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i) && !$past(scl_i, 2))
        else $error("data line changed outside clock low");
    a_oe_stand: assert property (scl_ff == 3'h7 |=> $stable(sda_oe_o))
        else $error("data line changed while clock high");
    cover property ($rose(int_oe_o));
    cover property (bus_ff == BUS_TIMEOUT_CYC);
    cover property ($rose(sda_oe_o));
endmodule : rtc_chk

bind rtc_core rtc_chk #(.BUS_TIMEOUT_CYC(BUS_TIMEOUT_CYC)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .xtal_i(xtal_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .int_n_o(int_n_o), .int_oe_o(int_oe_o));

// *** rtc_host.sv ***
`timescale 1ns/100ps
module rtc_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wt
    // One bit, MSB first bytes, data changes only while the clock is low
    task automatic bitx(input logic b, input int pause, output logic r);
        sda_low_o = ~b;
        wt(4);
        scl_o = 1'b1;
        wt(4);
        r = sda_i;
        wt(4);
        scl_o = 1'b0;
        wt(4 + pause);
    endtask : bitx
    task automatic start();
        sda_low_o = 1'b0;
        wt(4);
        scl_o = 1'b1;
        wt(4);
        sda_low_o = 1'b1;
        wt(4);
        scl_o = 1'b0;
        wt(4);
    endtask : start
    // Stop ends each transaction; only the stalled one outlasts the bus timeout
    task automatic stop();
        sda_low_o = 1'b1;
        wt(4);
        scl_o = 1'b1;
        wt(4);
        sda_low_o = 1'b0;
        wt(4);
    endtask : stop
    task automatic xfer(input logic [7:0] d, input logic hack, input int pause,
                        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], i == 0 ? pause : 0, r);
            q[i] = r;
        end
        bitx(hack, 0, ack);
    endtask : xfer
endmodule : rtc_host

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
    localparam int unsigned TMO = 3000;
    logic clk_i, rstn_i, xtal_i, scl, sda_low, sda, sda_o, sda_oe_o, int_n_o, int_oe_o, ack;
    logic [31:0] seed;
    logic [7:0] q, ld, wd, yr;
    logic [7:0] wb [0:6];
    logic [7:0] rb [0:6];
    logic [7:0] ex [0:6];
    int n_fail, n_compared, n_int, hi, per;
    assign sda = ~(sda_low | sda_oe_o);
    rtc_core #(.BUS_TIMEOUT_CYC(TMO)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .xtal_i(xtal_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_n_o(int_n_o),
        .int_oe_o(int_oe_o));
    rtc_host u_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        xtal_i = 1'b0;
        #7;
        forever #160 xtal_i = ~xtal_i;
    end
    always @(negedge clk_i) if (int_oe_o === 1'b1) n_int++;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input int tol);
        logic ok;
        ok = (seen === exp) || (tol > 0 && seen + tol >= exp && seen <= exp + tol);
        n_compared++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input int n);
        u_host.start();
        u_host.xfer({rtc_pkg::DEV_ADDR, 1'b0}, 1'b1, 0, q, ack);
        u_host.xfer({4'h0, a}, 1'b1, 0, q, ack);
        for (int i = 0; i < n; i++) u_host.xfer(wb[i], 1'b1, 0, q, ack);
        chk({15'h0, ack}, 16'h0, 0);
        u_host.stop();
    endtask : wr
    task automatic rdr(input logic [3:0] a, input int n);
        u_host.start();
        u_host.xfer({rtc_pkg::DEV_ADDR, 1'b0}, 1'b1, 0, q, ack);
        u_host.xfer({4'h0, a}, 1'b1, 0, q, ack);
        u_host.start();
        u_host.xfer({rtc_pkg::DEV_ADDR, 1'b1}, 1'b1, 0, q, ack);
        for (int i = 0; i < n; i++) u_host.xfer(8'hff, i == n - 1, 0, rb[i], ack);
        u_host.stop();
    endtask : rdr
    // Interrupt high time and period, in clocks
    task automatic meas(output int h, output int p);
        int k = 0;
        while (int_oe_o !== 1'b1 && k < 300000) begin
            @(negedge clk_i);
            k++;
        end
        h = 0;
        while (int_oe_o === 1'b1 && h < 9000) begin
            @(negedge clk_i);
            h++;
        end
        p = h;
        while (int_oe_o !== 1'b1 && p < 300000) begin
            @(negedge clk_i);
            p++;
        end
        while (int_oe_o === 1'b1 && k < 310000) begin
            @(negedge clk_i);
            k++;
        end
    endtask : meas
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (400000) @(posedge clk_i);
        n_fail++;
        print_verdict();
    end
    initial begin
        seed = 32'h6304a2ee;
        n_fail = 0;
        n_compared = 0;
        n_int = 0;
        rstn_i = 1'b0;
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        rdr(4'h0, 7);
        for (int i = 0; i < 7; i++) chk({8'h0, rb[i]}, (i == 4 || i == 5) ? 16'h1 : 16'h0, 0);
        // Stall in the address ack past the timeout
        u_host.start();
        u_host.xfer({rtc_pkg::DEV_ADDR, 1'b0}, 1'b1, TMO + 200, q, ack);
        chk({15'h0, ack}, 16'h1, 0);
        u_host.xfer(8'h00, 1'b1, 0, q, ack);
        u_host.xfer(8'h05, 1'b1, 0, q, ack);
        chk({15'h0, ack}, 16'h1, 0);
        u_host.stop();
        rdr(4'h0, 1);
        chk({8'h0, rb[0]}, 16'h0, 0);
        for (int s = 0; s < 4; s++) begin
            wb[0] = 8'hff;
            wb[1] = 8'h0f;
            wb[2] = {5'h0, ~s[1], s[1:0]};
            wr(4'h7, 3);
            rdr(4'h7, 3);
            for (int i = 0; i < 3; i++) chk({8'h0, rb[i]}, {8'h0, wb[i]}, 0);
        end
        repeat (3) begin
            ld = 8'h01 + 8'(xs() % 15);
            wb[0] = ld;
            wb[1] = 8'h00;
            wb[2] = 8'h04;
            n_int = 0;
            wr(4'h7, 3);
            repeat (int'(ld) * 128 + 200) @(negedge clk_i);
            wb[0] = 8'h00;
            wr(4'h9, 1);
            chk(16'(n_int), 16'h0, 0);
            rdr(4'ha, 1);
            chk({15'h0, rb[0][4]}, 16'h1, 0);
            wb[0] = 8'hff;
            wr(4'ha, 1);
            rdr(4'ha, 1);
            chk({15'h0, rb[0][4]}, 16'h1, 0);
            wb[0] = 8'h00;
            wr(4'ha, 1);
            rdr(4'ha, 1);
            chk({15'h0, rb[0][4]}, 16'h0, 0);
        end
        wb[0] = 8'h10;
        wr(4'hb, 1);
        for (int s = 0; s < 2; s++) begin
            ld = (s == 0) ? 8'h01 + 8'(xs() % 2) : 8'h21 + 8'(xs() % 31);
            wb[0] = ld;
            wb[1] = 8'h00;
            wb[2] = {7'h02, ~s[0]};
            wr(4'h7, 3);
            meas(hi, per);
            chk(16'(hi), 16'h07f8, 9);
            chk(16'(per), 16'(int'(ld) * ((s == 0) ? 4096 : 64)), 2);
        end
        wb[0] = 8'h00;
        wr(4'h9, 1);
        repeat (2100) @(negedge clk_i);
        wr(4'hb, 1);
        wd = 8'(xs() % 6);
        yr = 8'(4 * (xs() % 25));
        wb = '{8'h3b, 8'h3b, 8'h17, wd, 8'h1c, 8'h02, yr};
        wr(4'h0, 7);
        repeat (32768 * 8) @(negedge clk_i);
        rdr(4'h0, 7);
        ex = '{8'h00, 8'h00, 8'h00, wd + 8'h01, 8'h1d, 8'h02, yr};
        for (int i = 0; i < 7; i++) chk({8'h0, rb[i]}, {8'h0, ex[i]}, 0);
        print_verdict();
    end
endmodule : testbench
